// [plcr_pkg.sv]
// Package for the photo LED configuration register bank: offsets, fields, resets, types.
// Assumes a 32-bit AXI4-Lite register bus; offsets are register indices, byte address is 4x.
package plcr_pkg;
  localparam logic [7:0] IDX_LED_REGULATOR_VOLTAGE = 8'h0f;
  localparam logic [7:0] IDX_PHOTO_CONTROL = 8'h10;
  localparam logic [7:0] IDX_LED_A_DAC_REGISTER = 8'h11;
  localparam logic [7:0] IDX_LED_B_DAC_REGISTER = 8'h12;
  localparam int ADDR_W = 10;
  localparam logic [2:0] RST_LED_REGULATOR_VOLTAGE = 3'h0;
  localparam logic [6:0] RST_PHOTO_CONTROL = 7'h00;
  localparam logic [7:0] RST_LED_DAC = 8'h00;
  localparam int REG_LSB = 1;
  localparam int REG_MSB = 3;
  localparam int TCB_LSB = 5;
  localparam int TCA_LSB = 3;
  localparam int PHOTO_REFERENCE_PIN_BIT = 2;
  localparam int GAIN_LSB = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] led_regulator_voltage;
    logic [1:0] led_b_temp_coeff;
    logic [1:0] led_a_temp_coeff;
    logic photo_reference_select;
    logic [1:0] photo_gain;
    logic [7:0] led_a_dac_code;
    logic [7:0] led_b_dac_code;
  } plcr_cfg_t;

  typedef struct packed {
    logic hit;
    logic [7:0] data;
  } plcr_rd_t;
endpackage : plcr_pkg

// [plcr_decode.sv]
// Read decoder for the photo LED configuration bank.
// Assumes the register index is already extracted from the word-aligned byte address.
`timescale 1ns/1ns
module plcr_decode
  import plcr_pkg::*;
(
  input wire logic [7:0] index_i,
  input wire plcr_cfg_t cfg_i,
  output plcr_rd_t rd_o
);
  always_comb begin
    rd_o = '{hit: 1'b1, data: 8'h00};
    unique case (index_i)
      IDX_LED_REGULATOR_VOLTAGE: begin
        rd_o.data[REG_MSB:REG_LSB] = cfg_i.led_regulator_voltage;
      end
      IDX_PHOTO_CONTROL: begin
        rd_o.data[TCB_LSB+:2] = cfg_i.led_b_temp_coeff;
        rd_o.data[TCA_LSB+:2] = cfg_i.led_a_temp_coeff;
        rd_o.data[PHOTO_REFERENCE_PIN_BIT] = cfg_i.photo_reference_select;
        rd_o.data[GAIN_LSB+:2] = cfg_i.photo_gain;
      end
      IDX_LED_A_DAC_REGISTER: begin
        rd_o.data = cfg_i.led_a_dac_code;
      end
      IDX_LED_B_DAC_REGISTER: begin
        rd_o.data = cfg_i.led_b_dac_code;
      end
      default: begin
        rd_o.hit = 1'b0;
      end
    endcase
  end
endmodule : plcr_decode

// [plcr_regs.sv]
// AXI4-Lite slave holding the photo chamber LED and amplifier configuration.
// Assumes a single clock; settings drive analog controls as plain outputs.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
module plcr_regs
  import plcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [2:0] led_regulator_voltage_o,
  output logic [1:0] led_a_temp_coeff_o,
  output logic [1:0] led_b_temp_coeff_o,
  output logic photo_reference_select_o,
  output logic photo_reference_pin_en_o,
  output logic [1:0] photo_gain_o,
  output logic [7:0] led_a_dac_code_o,
  output logic [7:0] led_b_dac_code_o
);
  plcr_cfg_t cfg_reg, cfg_next;
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [7:0] aw_idx_reg, aw_idx_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] wr_idx;
  logic do_write;
  plcr_rd_t wr_dec, rd_dec;
  logic aw_take, w_take;
  logic [7:0] wd_now;
  logic st_now;

  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
    word_index = addr[ADDR_W-1:2];
  endfunction : word_index

  // Readies drop while frozen, so a master never sees an AW, W or AR handshake the bank does not register.
  assign s_axi_awready = clk_en_i && !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = clk_en_i && !w_held_reg && !bvalid_reg;
  assign s_axi_arready = clk_en_i && !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = {24'h000000, rdata_reg};

  // The write path is built from registered state and bus inputs only, which avoids a loop.
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_idx = aw_take ? word_index(s_axi_awaddr) : aw_idx_reg;
  assign wd_now = w_take ? s_axi_wdata[7:0] : wdata_reg;
  assign st_now = w_take ? s_axi_wstrb[0] : wstrb0_reg;
  assign do_write = (aw_held_reg || aw_take) && (w_held_reg || w_take) && !bvalid_reg;

  plcr_decode u_wr_decode (
    .index_i(wr_idx),
    .cfg_i(cfg_reg),
    .rd_o(wr_dec)
  );

  plcr_decode u_rd_decode (
    .index_i(word_index(s_axi_araddr)),
    .cfg_i(cfg_reg),
    .rd_o(rd_dec)
  );

  // Write channel: address and data are latched independently, in either order.
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    aw_idx_next = aw_idx_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    cfg_next = cfg_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_idx_next = word_index(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata[7:0];
      wstrb0_next = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_dec.hit ? RESP_OKAY : RESP_SLVERR;
      if (wr_dec.hit && st_now) begin
        unique case (wr_idx)
          IDX_LED_REGULATOR_VOLTAGE: begin
            cfg_next.led_regulator_voltage = wd_now[REG_MSB:REG_LSB];
          end
          IDX_PHOTO_CONTROL: begin
            cfg_next.led_b_temp_coeff = wd_now[TCB_LSB+:2];
            cfg_next.led_a_temp_coeff = wd_now[TCA_LSB+:2];
            cfg_next.photo_reference_select = wd_now[PHOTO_REFERENCE_PIN_BIT];
            cfg_next.photo_gain = wd_now[GAIN_LSB+:2];
          end
          IDX_LED_A_DAC_REGISTER: begin
            cfg_next.led_a_dac_code = wd_now;
          end
          IDX_LED_B_DAC_REGISTER: begin
            cfg_next.led_b_dac_code = wd_now;
          end
          default: begin
            cfg_next = cfg_reg;
          end
        endcase
      end
    end
  end

  // Read channel: data is captured when the address is taken.
  always_comb begin
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rdata_next = rd_dec.data;
      rresp_next = rd_dec.hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_reg <= '{led_regulator_voltage: RST_LED_REGULATOR_VOLTAGE,
                   led_b_temp_coeff: RST_PHOTO_CONTROL[TCB_LSB+:2],
                   led_a_temp_coeff: RST_PHOTO_CONTROL[TCA_LSB+:2],
                   photo_reference_select: RST_PHOTO_CONTROL[PHOTO_REFERENCE_PIN_BIT],
                   photo_gain: RST_PHOTO_CONTROL[GAIN_LSB+:2],
                   led_a_dac_code: RST_LED_DAC,
                   led_b_dac_code: RST_LED_DAC};
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_idx_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 8'h00;
    end else if (clk_en_i) begin
      cfg_reg <= cfg_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      aw_idx_reg <= aw_idx_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // Settings go straight to the analog controls from their flip-flops.
  assign led_regulator_voltage_o = cfg_reg.led_regulator_voltage;
  assign led_a_temp_coeff_o = cfg_reg.led_a_temp_coeff;
  assign led_b_temp_coeff_o = cfg_reg.led_b_temp_coeff;
  assign photo_reference_select_o = cfg_reg.photo_reference_select;
  assign photo_reference_pin_en_o = cfg_reg.photo_reference_select;
  assign photo_gain_o = cfg_reg.photo_gain;
  assign led_a_dac_code_o = cfg_reg.led_a_dac_code;
  assign led_b_dac_code_o = cfg_reg.led_b_dac_code;
endmodule : plcr_regs

// [plcr_regs_assertions.sv]
// Checker for the photo LED configuration bank, bound to every plcr_regs instance.
// Assumes one clock and that a checked write offers AW and W together.
`timescale 1ns/1ns
module plcr_regs_assertions
  import plcr_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [2:0] led_regulator_voltage_o,
  input wire logic [1:0] led_a_temp_coeff_o,
  input wire logic [1:0] led_b_temp_coeff_o,
  input wire logic photo_reference_select_o,
  input wire logic photo_reference_pin_en_o,
  input wire logic [1:0] photo_gain_o,
  input wire logic [7:0] led_a_dac_code_o,
  input wire logic [7:0] led_b_dac_code_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire go = clk_en_i && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_wstrb[0];
  wire [7:0] wi = s_axi_awaddr[ADDR_W-1:2];
  wire hv = go && wi == IDX_LED_REGULATOR_VOLTAGE;
  wire hp = go && wi == IDX_PHOTO_CONTROL;
  property p_rst; !$past(resetn_i) |-> {led_regulator_voltage_o, led_a_temp_coeff_o,
    led_b_temp_coeff_o, photo_reference_select_o, photo_gain_o, led_a_dac_code_o,
    led_b_dac_code_o} == '0; endproperty
  a_rst: assert property (p_rst) else $error("settings not zero after reset");
  property p_vreg; hv |=> led_regulator_voltage_o == $past(s_axi_wdata[3:1]); endproperty
  a_vreg: assert property (p_vreg) else $error("regulator code wrong");
  property p_tcb; hp |=> led_b_temp_coeff_o == $past(s_axi_wdata[6:5]); endproperty
  a_tcb: assert property (p_tcb) else $error("led b coefficient wrong");
  property p_tca; hp |=> led_a_temp_coeff_o == $past(s_axi_wdata[4:3]); endproperty
  a_tca: assert property (p_tca) else $error("led a coefficient wrong");
  property p_sel; hp |=> photo_reference_select_o == $past(s_axi_wdata[2]); endproperty
  a_sel: assert property (p_sel) else $error("reference select wrong");
  property p_pin; photo_reference_pin_en_o == photo_reference_select_o; endproperty
  a_pin: assert property (p_pin) else $error("reference pin differs from select");
  property p_gain; hp |=> photo_gain_o == $past(s_axi_wdata[1:0]); endproperty
  a_gain: assert property (p_gain) else $error("photo gain wrong");
  property p_daca; go && wi == IDX_LED_A_DAC_REGISTER |=>
    led_a_dac_code_o == $past(s_axi_wdata[7:0]); endproperty
  a_daca: assert property (p_daca) else $error("led a code wrong");
  property p_dacb; go && wi == IDX_LED_B_DAC_REGISTER |=>
    led_b_dac_code_o == $past(s_axi_wdata[7:0]); endproperty
  a_dacb: assert property (p_dacb) else $error("led b code wrong");
endmodule : plcr_regs_assertions

bind plcr_regs plcr_regs_assertions u_chk (.*);

// [test_plcr_regs.sv]
// Self-checking bench for the photo LED configuration bank over AXI4-Lite.
// Assumes the slave answers each request well inside the watchdog span.
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module test_plcr_regs;
  import plcr_pkg::*;
  logic clk_i = 1'h0, resetn_i = 1'h0, clk_en_i = 1'h1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rq;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sel, pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, tca, tcb, gain;
  logic [2:0] vr;
  logic [7:0] da, db;
  int fails = 0, num_checks = 0;
  plcr_regs uut (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0),
    .led_regulator_voltage_o(vr), .led_a_temp_coeff_o(tca), .led_b_temp_coeff_o(tcb),
    .photo_reference_select_o(sel), .photo_reference_pin_en_o(pin), .photo_gain_o(gain),
    .led_a_dac_code_o(da), .led_b_dac_code_o(db));
  always #10 clk_i = ~clk_i;
  task automatic wr(input logic [7:0] i, input logic [7:0] v, input logic [3:0] st);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    @(posedge clk_i);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, v};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_i);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clk_i); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] i);
    @(posedge clk_i);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk_i); while (!s_axi_rvalid);
    rq = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic t_reset;
    for (logic [7:0] i = IDX_LED_REGULATOR_VOLTAGE; i <= IDX_LED_B_DAC_REGISTER; i++) begin
      rd(i);
      `CHK("reset read", {32'h0, RESP_OKAY}, {rq, r})
    end
    `CHK("reset outputs", 27'h0, {vr, tca, tcb, sel, pin, gain, da, db})
    $display("test reset done");
  endtask : t_reset
  task automatic t_fields;
    for (logic [3:0] k = 4'h0; k < 4'h6; k++) begin
      wr(IDX_LED_REGULATOR_VOLTAGE, {4'hf, k[2:0], 1'h1}, 4'h1);
      `CHK("regulator", k[2:0], vr)
      rd(IDX_LED_REGULATOR_VOLTAGE);
      `CHK("regulator read", {28'h0, k[2:0], 1'h0}, rq)
    end
    for (logic [2:0] k = 3'h0; k < 3'h4; k++) begin
      wr(IDX_PHOTO_CONTROL, {1'h1, k[1:0], ~k[1:0], k[0], k[1:0] ^ 2'h1}, 4'h1);
      `CHK("led b coeff", k[1:0], tcb)
      `CHK("led a coeff", ~k[1:0], tca)
      `CHK("ref select", {k[0], k[0]}, {sel, pin})
      `CHK("gain", k[1:0] ^ 2'h1, gain)
      rd(IDX_PHOTO_CONTROL);
      `CHK("photo read", {25'h0, k[1:0], ~k[1:0], k[0], k[1:0] ^ 2'h1}, rq)
    end
    $display("test fields done");
  endtask : t_fields
  task automatic t_dac;
    wr(IDX_LED_A_DAC_REGISTER, 8'hff, 4'h1);
    wr(IDX_LED_B_DAC_REGISTER, 8'h00, 4'h1);
    `CHK("dac pair", 16'hff00, {da, db})
    wr(IDX_LED_B_DAC_REGISTER, 8'hff, 4'h1);
    wr(IDX_LED_A_DAC_REGISTER, 8'h00, 4'h1);
    wr(IDX_LED_A_DAC_REGISTER, 8'h5a, 4'h0);
    `CHK("strobe off resp", RESP_OKAY, r)
    `CHK("dac pair swapped", 16'h00ff, {da, db})
    rd(IDX_LED_B_DAC_REGISTER);
    `CHK("dac b read", 32'hff, rq)
    wr(8'h13, 8'h77, 4'h1);
    `CHK("unmapped write", RESP_SLVERR, r)
    rd(8'h13);
    `CHK("unmapped read", {32'h0, RESP_SLVERR}, {rq, r})
    `CHK("dac untouched", 16'h00ff, {da, db})
    $display("test dac done");
  endtask : t_dac
  task automatic t_freeze;
    clk_en_i <= 1'h0;
    fork
      wr(IDX_LED_A_DAC_REGISTER, 8'h3c, 4'h1);
      begin
        repeat (5) @(posedge clk_i);
        `CHK("frozen dac a", 8'h00, da)
        clk_en_i <= 1'h1;
      end
    join
    `CHK("unfrozen dac a", 8'h3c, da)
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_rerun;
    @(posedge clk_i);
    resetn_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    `CHK("mid-run reset outputs", 27'h0, {vr, tca, tcb, sel, pin, gain, da, db})
    resetn_i <= 1'h1;
    t_reset;
    $display("test rerun done");
  endtask : t_rerun
  task automatic conclude;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  initial begin
    #200000;
    fails++;
    conclude;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'h1;
    t_reset;
    t_fields;
    t_dac;
    t_freeze;
    t_rerun;
    conclude;
  end
endmodule : test_plcr_regs
